//--- core/mac_unit.sv
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - trigger select picks which write, or the soft start, launches a calculation
// - a result outside the accumulator range sets the overflow flag
// - overflow flag stays set through later in-range results
// - reads keep the flag; software writes zero to clear it
// - unsigned: overflow above 2^64-1 or below zero
// - signed: overflow above 2^63-1 or below -2^63
// - control 0x08: unsigned accumulate, each operand B write with byte lane 0 starts one
// - control 0x25: signed acc-minus-product, a bit 5 write while already in soft mode starts it
// - new operand B multiplies with the held operand A onto last result
// - mode 00 add, 01 acc minus product, 10 product minus acc, 11 none
// - low half ready one clock after start, high half after two
module mac_unit
#(
  parameter int ADDR_W = 16
)
(
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire mac_pkg::mac_wb_req_s wb_req,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o
);

  // the decode compares full 16-bit offsets
  if (ADDR_W != 16)
  begin : g_bad_addr
    $error("mac_unit: ADDR_W must be 16");
  end

  // byte-lane merge used by every writable data register
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    return r;
  endfunction

  logic [31:0] opa_q;
  logic [31:0] opb_q;
  logic [31:0] acc_l_q;
  logic [31:0] acc_h_q;
  logic [5:0]  cfg_q;      // trigger, sign and mode bits
  logic        ovf_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        calc_q;     // first cycle after a start
  logic        hi_pend_q;  // high half still to be written
  logic [31:0] hi_hold_q;
  logic        ovf_hold_q;

  logic        take;
  logic        wr;
  logic        wr_l0;
  logic        hit_opa;
  logic        hit_opb;
  logic        hit_acc_l;
  logic        hit_acc_h;
  logic        hit_ctrl;
  logic [2:0]  trig;
  logic [2:0]  trig_new;
  logic        soft_go;
  logic        start;
  logic        ovf_clr;
  logic        ovf_set;
  logic [5:0]  cfg_d;
  logic [31:0] ctrl_rd;
  logic [31:0] rd_mux;
  logic [63:0] alu_res;
  logic        alu_ovf;
  logic        alu_ok;

  // a request is taken in the cycle it is seen while no ack is out
  assign take      = wb_req.cyc && wb_req.stb && !ack_q;
  assign wr        = take && wb_req.we;
  assign wr_l0     = wr && wb_req.sel[0];
  assign hit_opa   = (wb_req.adr == mac_pkg::OFS_OPA);
  assign hit_opb   = (wb_req.adr == mac_pkg::OFS_OPB);
  assign hit_acc_l = (wb_req.adr == mac_pkg::OFS_ACC_L);
  assign hit_acc_h = (wb_req.adr == mac_pkg::OFS_ACC_H);
  assign hit_ctrl  = (wb_req.adr == mac_pkg::OFS_CTRL);

  // only the lowest byte lane launches, so partial writes can finish first
  assign trig     = cfg_q[mac_pkg::CTRL_TRIG_MSB:mac_pkg::CTRL_TRIG_LSB];
  assign trig_new = wb_req.dat[mac_pkg::CTRL_TRIG_MSB:mac_pkg::CTRL_TRIG_LSB];
  // soft start: bit 5 written with bit 6 set, or bit 5 rewritten while already in soft mode
  assign soft_go  = wr_l0 && hit_ctrl && trig_new[2]
                    && (wb_req.dat[mac_pkg::CTRL_START_BIT] || trig[2]);
  assign start    = soft_go
                    || (wr_l0 && hit_opa && trig == mac_pkg::TRIG_OPA)
                    || (wr_l0 && hit_opb && trig == mac_pkg::TRIG_OPB)
                    || (wr_l0 && hit_acc_l && trig == mac_pkg::TRIG_ACC_L)
                    || (wr_l0 && hit_acc_h
                        && trig == mac_pkg::TRIG_ACC_H);

  // control write keeps the new trigger, sign and mode fields
  assign cfg_d = (wr_l0 && hit_ctrl)
                 ? wb_req.dat[mac_pkg::CTRL_TRIG_MSB:mac_pkg::CTRL_MODE_LSB]
                 : cfg_q;

  // a zero written to the flag clears it; a one written is ignored
  assign ovf_clr = wr_l0 && hit_ctrl
                   && !wb_req.dat[mac_pkg::CTRL_OVF_BIT];
  assign ovf_set = hi_pend_q && ovf_hold_q;

  // start bit always reads zero; unused upper bits read zero
  assign ctrl_rd = {24'h0, ovf_q, 1'b0, cfg_q};
  assign rd_mux  = hit_opa   ? opa_q   :
                   hit_opb   ? opb_q   :
                   hit_acc_l ? acc_l_q :
                   hit_acc_h ? acc_h_q :
                   hit_ctrl  ? ctrl_rd : 32'h0;

  // operands are the held registers, so a lone operand B write reuses A
  mac_alu u_alu
  (
    .op_a    (opa_q),
    .op_b    (opb_q),
    .acc     ({acc_h_q, acc_l_q}),
    .sgn     (cfg_q[mac_pkg::CTRL_SIGN_BIT]),
    .mode    (mac_pkg::mac_mode_e'(cfg_q[1:0])),
    .result  (alu_res),
    .ovf     (alu_ovf),
    .mode_ok (alu_ok)
  );

  // bus answer: ack one clock after the request is seen, read data with it
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ack_q <= 1'b0;
      dat_q <= mac_pkg::DATA_RESET;
    end
    else
    begin
      ack_q <= take;
      dat_q <= take ? rd_mux : dat_q;
    end
  end

  // operand registers and control fields
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      opa_q <= mac_pkg::DATA_RESET;
      opb_q <= mac_pkg::DATA_RESET;
      cfg_q <= mac_pkg::CTRL_RESET[5:0];
    end
    else
    begin
      opa_q <= (wr && hit_opa) ? lane_merge(opa_q, wb_req.dat, wb_req.sel)
                               : opa_q;
      opb_q <= (wr && hit_opb) ? lane_merge(opb_q, wb_req.dat, wb_req.sel)
                               : opb_q;
      cfg_q <= cfg_d;
    end
  end

  // calculation pipeline: low half first, high half one clock later
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      calc_q     <= 1'b0;
      hi_pend_q  <= 1'b0;
      hi_hold_q  <= mac_pkg::DATA_RESET;
      ovf_hold_q <= 1'b0;
    end
    else
    begin
      calc_q     <= start;
      hi_pend_q  <= calc_q && alu_ok;
      hi_hold_q  <= alu_res[63:32];
      ovf_hold_q <= alu_ovf;
    end
  end

  // accumulator halves; the calculation wins over a bus write in one cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      acc_l_q <= mac_pkg::DATA_RESET;
      acc_h_q <= mac_pkg::DATA_RESET;
    end
    else
    begin
      if (calc_q && alu_ok)
        acc_l_q <= alu_res[31:0];
      else if (wr && hit_acc_l)
        acc_l_q <= lane_merge(acc_l_q, wb_req.dat, wb_req.sel);
      if (hi_pend_q)
        acc_h_q <= hi_hold_q;
      else if (wr && hit_acc_h)
        acc_h_q <= lane_merge(acc_h_q, wb_req.dat, wb_req.sel);
    end
  end

  // sticky overflow: a set in the clearing cycle wins over the clear
  always_ff @(posedge mclk)
  begin
    if (rst)
      ovf_q <= 1'b0;
    else
      ovf_q <= ovf_set || (ovf_q && !ovf_clr);
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;

  // checks kept beside the logic they watch
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_b_launch;
    wr_l0 && hit_opb && trig == mac_pkg::TRIG_OPB;
  endsequence

  sequence s_calc_ok;
    calc_q && alu_ok && !(wr && hit_acc_h);
  endsequence

  a_trig_opb_start:
    assert property (s_b_launch |-> start ##1 calc_q)
    else $error("operand B write did not launch a calculation");

  a_trig_acc_start:
    assert property (wr_l0 && hit_acc_l && trig == mac_pkg::TRIG_ACC_L
                     |=> calc_q)
    else $error("accumulator write did not launch a calculation");

  a_soft_start_go:
    assert property (wr_l0 && hit_ctrl && trig[2] && trig_new[2]
                     |=> calc_q)
    else $error("soft start write did not launch a calculation");

  a_no_false_start:
    assert property (!take |=> !calc_q)
    else $error("calculation began without a bus write");

  a_result_halves:
    assert property (s_calc_ok |=> acc_l_q == $past(alu_res[31:0])
                     ##1 acc_h_q == $past(alu_res[63:32], 2))
    else $error("result halves not written at one and two clocks");

  a_ovf_flagged:
    assert property (calc_q && alu_ok && alu_ovf |-> ##2 ovf_q)
    else $error("overflow flag missed an out of range result");

  a_unsigned_range:
    assert property (calc_q && alu_ok && !cfg_q[mac_pkg::CTRL_SIGN_BIT]
                     && alu_res[63] == 1'b1 && !alu_ovf && !ovf_q
                     && !ovf_hold_q && !hi_pend_q |-> ##2 !ovf_q)
    else $error("unsigned in range result raised overflow");

  a_signed_range:
    assert property (calc_q && alu_ok && cfg_q[mac_pkg::CTRL_SIGN_BIT]
                     && !alu_ovf && !ovf_q && !hi_pend_q
                     && !ovf_hold_q |-> ##2 !ovf_q)
    else $error("signed in range result raised overflow");

  a_ovf_sticky:
    assert property (ovf_q && !ovf_clr |=> ovf_q [*1])
    else $error("overflow flag fell without a clearing write");

  a_ovf_cleared:
    assert property (ovf_clr && !ovf_set |=> !ovf_q)
    else $error("writing zero did not clear the overflow flag");

  a_read_keeps_ovf:
    assert property (take && !wb_req.we && !ovf_set |=> $stable(ovf_q))
    else $error("a read changed the overflow flag");

  a_rsvd_holds:
    assert property (calc_q && !alu_ok && !wr |=> $stable(acc_l_q)
                     ##1 ($stable(acc_h_q) || $past(wr)) && !ovf_set)
    else $error("reserved mode changed the accumulator");

  a_ack_one_cycle:
    assert property (ack_q |=> !ack_q)
    else $error("ack stood longer than one cycle");

endmodule // mac_unit
`default_nettype wire

//--- core/mac_pkg.sv
// shared constants and carriers for the multiply-accumulate unit
package mac_pkg;

  // register byte addresses
  localparam logic [15:0] OFS_OPA   = 16'h1be0;
  localparam logic [15:0] OFS_OPB   = 16'h1be4;
  localparam logic [15:0] OFS_ACC_L = 16'h1be8;
  localparam logic [15:0] OFS_ACC_H = 16'h1bec;
  localparam logic [15:0] OFS_CTRL  = 16'h1bfc;

  // control register field positions
  localparam int CTRL_OVF_BIT   = 7;
  localparam int CTRL_START_BIT = 6;
  localparam int CTRL_TRIG_MSB  = 5;
  localparam int CTRL_TRIG_LSB  = 3;
  localparam int CTRL_SIGN_BIT  = 2;
  localparam int CTRL_MODE_MSB  = 1;
  localparam int CTRL_MODE_LSB  = 0;

  // reset values
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;

  // trigger select codes; any code with the top bit set is soft start
  localparam logic [2:0] TRIG_OPA   = 3'h0;
  localparam logic [2:0] TRIG_OPB   = 3'h1;
  localparam logic [2:0] TRIG_ACC_L = 3'h2;
  localparam logic [2:0] TRIG_ACC_H = 3'h3;

  // calculation modes
  typedef enum logic [1:0] {
    MODE_ADD  = 2'h0,
    MODE_SUB  = 2'h1,
    MODE_RSUB = 2'h2,
    MODE_RSVD = 2'h3
  } mac_mode_e;

  // cycles from start to the low and high result halves
  localparam int LOW_VALID_CYC  = 1;
  localparam int HIGH_VALID_CYC = 2;

  // classic wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [15:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } mac_wb_req_s;

endpackage

//--- core/mac_alu.sv
`timescale 1ns/1ps
`default_nettype none
// one-step 32x32 multiply with 64-bit accumulate and range check
module mac_alu
(
  input  wire logic [31:0]       op_a,
  input  wire logic [31:0]       op_b,
  input  wire logic [63:0]       acc,
  input  wire logic              sgn,
  input  wire mac_pkg::mac_mode_e mode,
  output logic      [63:0]       result,
  output logic                   ovf,
  output logic                   mode_ok
);

  logic signed [32:0] a_x;
  logic signed [32:0] b_x;
  logic signed [65:0] prod;
  logic signed [65:0] acc_x;
  logic signed [65:0] sum;

  // widen by one sign or zero bit so both modes share one signed multiplier
  assign a_x   = {sgn & op_a[31], op_a};
  assign b_x   = {sgn & op_b[31], op_b};
  assign prod  = a_x * b_x;
  assign acc_x = {{2{sgn & acc[63]}}, acc};

  // operation select; reserved code produces no result
  always_comb
  begin
    unique case (mode)
      mac_pkg::MODE_ADD:  sum = acc_x + prod;
      mac_pkg::MODE_SUB:  sum = acc_x - prod;
      mac_pkg::MODE_RSUB: sum = prod - acc_x;
      mac_pkg::MODE_RSVD: sum = acc_x;
    endcase
  end

  // out of range: unsigned needs top two bits clear, signed needs top three bits equal
  assign ovf     = sgn ? !(sum[65:63] == 3'h0 || sum[65:63] == 3'h7)
                       : (sum[65:64] != 2'h0);
  assign result  = sum[63:0];
  assign mode_ok = (mode != mac_pkg::MODE_RSVD);

endmodule // mac_alu
`default_nettype wire

//--- verification/mac_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// cpu side of the register bus: one classic cycle per call, lanes by caller
module mac_cpu_model
(
  input  wire logic                 mclk,
  input  wire logic [31:0]          wb_dat_o,
  input  wire logic                 wb_ack_o,
  output var  mac_pkg::mac_wb_req_s wb_req
);
  initial wb_req = '0;

  // request held until ack is seen at an edge, then released after it
  task automatic xfer(input logic we, input logic [15:0] adr,
                      input logic [31:0] dat, input logic [3:0] sel,
                      output logic [31:0] rdat);
    @(posedge mclk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel,
                dat: dat};
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_req <= '0;
  endtask
endmodule // mac_cpu_model
`default_nettype wire

//--- verification/tb_mac_unit.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin checks++; if ((got) !== (exp)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module tb_mac_unit;
  logic                 mclk = 1'b0;
  logic                 rst = 1'b1;
  int                   err_count = 0;
  int                   checks = 0;
  int                   cyc_n = 0;
  logic [31:0]          rd_v;
  logic [31:0]          a;
  logic [31:0]          b;
  logic [63:0]          c;
  logic [64:0]          e;
  logic [7:0]           cw;
  mac_pkg::mac_wb_req_s wb_req;
  logic [31:0]          wb_dat_o;
  logic                 wb_ack_o;

  always #2 mclk = ~mclk;

  // watchdog: the whole run needs well under a thousand bus cycles
  always @(posedge mclk)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      err_count++;
      stop_test();
    end
  end

  mac_unit #(.ADDR_W(16)) i_mac_unit (
    .mclk     (mclk),
    .rst      (rst),
    .wb_req   (wb_req),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o)
  );

  mac_cpu_model i_mac_cpu_model (
    .mclk     (mclk),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .wb_req   (wb_req)
  );

  // true result on 66 bits so both range ends stay visible
  function automatic logic [64:0] mac_exp(logic [31:0] x, logic [31:0] y,
                                          logic [63:0] z, logic s,
                                          logic [1:0] m);
    logic signed [65:0] px;
    logic signed [65:0] py;
    logic signed [65:0] pz;
    logic signed [65:0] r;
    px = s ? {{34{x[31]}}, x} : {34'h0, x};
    py = s ? {{34{y[31]}}, y} : {34'h0, y};
    pz = s ? {{2{z[63]}}, z} : {2'h0, z};
    r = (m == 2'h0) ? pz + px * py : (m == 2'h1) ? pz - px * py
                                                 : px * py - pz;
    return {s ? (r[65:63] != 3'h0 && r[65:63] != 3'h7) : (r[65:64] != 0),
            r[63:0]};
  endfunction

  task automatic wr(input logic [15:0] ad, input logic [31:0] d);
    i_mac_cpu_model.xfer(1'b1, ad, d, 4'hf, rd_v);
  endtask

  // byte-lane write, so the launching low byte can come last
  task automatic wrb(input logic [15:0] ad, input logic [31:0] d,
                     input logic [3:0] s);
    i_mac_cpu_model.xfer(1'b1, ad, d, s, rd_v);
  endtask

  task automatic rd(input logic [15:0] ad);
    i_mac_cpu_model.xfer(1'b0, ad, 32'h0, 4'hf, rd_v);
  endtask

  // control first (clears the flag), then accumulator, then a and b
  task automatic run(input logic [7:0] ctl, input logic [63:0] acc,
                     input logic [31:0] oa, input logic [31:0] ob);
    wr(mac_pkg::OFS_CTRL, {24'h0, ctl});
    wr(mac_pkg::OFS_ACC_L, acc[31:0]);
    wr(mac_pkg::OFS_ACC_H, acc[63:32]);
    wr(mac_pkg::OFS_OPA, oa);
    wr(mac_pkg::OFS_OPB, ob);
  endtask

  // low half first, the high half settles one clock later
  task automatic chk_acc(input logic [63:0] x);
    rd(mac_pkg::OFS_ACC_L);
    `CHK(rd_v, x[31:0])
    rd(mac_pkg::OFS_ACC_H);
    `CHK(rd_v, x[63:32])
  endtask

  task automatic chk_ctl(input logic [7:0] x);
    rd(mac_pkg::OFS_CTRL);
    `CHK(rd_v, {24'h0, x})
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // directed cases, then random ones through the operand b trigger
  initial
  begin
    void'($urandom(32'hd6a5517d));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    chk_ctl(8'h00);
    rd(16'h1bf0);
    `CHK(rd_v, 32'h0)
    $display("test reset done");
    run(8'h08, 64'h33333333, 32'h11111111, 32'h22222222);
    chk_acc(64'h02468acf_41fdb975);
    wr(mac_pkg::OFS_OPB, 32'h44444444);
    chk_acc(64'h06d3a06d_5f92c5f9);
    $display("test accumulate done");
    // first control write only arms the soft start
    run(8'h25, 64'h33333333, 32'h11111111, 32'hdddddddd + 32'h1);
    chk_acc(64'h33333333);
    wr(mac_pkg::OFS_CTRL, 32'h25);
    chk_acc(64'h02468acf_41fdb975);
    chk_ctl(8'h25);
    $display("test soft start done");
    // trigger on a: the later b write must not start
    run(8'h00, 64'h5, 32'h3, 32'h7);
    e = mac_exp(32'h3, 32'hddddddde, 64'h5, 1'b0, 2'h0);
    chk_acc(e[63:0]);
    run(8'h0b, 64'h12345, 32'h3, 32'h7);
    chk_acc(64'h12345);
    chk_ctl(8'h0b);
    $display("test triggers done");
    // acc low, acc high and bit 6 launches, then operand a upper three bytes first, low byte last
    wr(mac_pkg::OFS_CTRL, 32'h10);
    wr(mac_pkg::OFS_OPA, 32'h5);
    wr(mac_pkg::OFS_OPB, 32'h6);
    wr(mac_pkg::OFS_ACC_H, 32'h1);
    wr(mac_pkg::OFS_ACC_L, 32'h7);
    e = mac_exp(32'h5, 32'h6, 64'h1_00000007, 1'b0, 2'h0);
    chk_acc(e[63:0]);
    wr(mac_pkg::OFS_CTRL, 32'h18);
    wr(mac_pkg::OFS_ACC_H, 32'h2);
    e = mac_exp(32'h5, 32'h6, {32'h2, e[31:0]}, 1'b0, 2'h0);
    chk_acc(e[63:0]);
    wr(mac_pkg::OFS_CTRL, 32'h61);
    e = mac_exp(32'h5, 32'h6, e[63:0], 1'b0, 2'h1);
    chk_acc(e[63:0]);
    chk_ctl(8'h21);
    wr(mac_pkg::OFS_CTRL, 32'h00);
    wrb(mac_pkg::OFS_OPA, 32'h12345600, 4'he);
    chk_acc(e[63:0]);
    wrb(mac_pkg::OFS_OPA, 32'h00000078, 4'h1);
    e = mac_exp(32'h12345678, 32'h6, e[63:0], 1'b0, 2'h0);
    chk_acc(e[63:0]);
    $display("test launch codes done");
    run(8'h08, 64'hffffffff_ffffffff, 32'h2, 32'h3);
    chk_ctl(8'h88);
    chk_ctl(8'h88);
    wr(mac_pkg::OFS_ACC_L, 32'h0);
    wr(mac_pkg::OFS_ACC_H, 32'h0);
    wr(mac_pkg::OFS_OPB, 32'h1);
    chk_ctl(8'h88);
    wr(mac_pkg::OFS_CTRL, 32'h08);
    chk_ctl(8'h08);
    run(8'h0c, 64'h7fffffff_ffffffff, 32'h1, 32'h1);
    chk_ctl(8'h8c);
    $display("test overflow done");
    repeat (40)
    begin
      cw = {2'b00, 3'b001, 1'($urandom), 2'($urandom % 3)};
      a = $urandom;
      b = $urandom;
      c = {$urandom, $urandom};
      run(cw, c, a, b);
      e = mac_exp(a, b, c, cw[2], cw[1:0]);
      chk_acc(e[63:0]);
      chk_ctl({e[64], cw[6:0]});
    end
    $display("test random done");
    stop_test();
  end
endmodule // tb_mac_unit
`default_nettype wire
